// *** common/clkss_pkg.sv ***
// constants, types and helpers of the clock source switch controller
// assumes: one clock domain, software writes one byte of the control word per cycle
package clkss_pkg;

  // ==========================================================
  // source codes and oscillator indices
  typedef logic [2:0] clkss_src_t;
  localparam clkss_src_t SRC_FRC     = 3'h0;
  localparam clkss_src_t SRC_FRC_PLL = 3'h1;
  localparam clkss_src_t SRC_PRI     = 3'h2;
  localparam clkss_src_t SRC_PRI_PLL = 3'h3;
  localparam clkss_src_t SRC_SEC     = 3'h4;
  localparam clkss_src_t SRC_SLOW_RC_OSCILLATOR    = 3'h5;
  localparam clkss_src_t SRC_FRC16   = 3'h6;
  localparam clkss_src_t SRC_FRCDIV  = 3'h7;

  localparam int NUM_OSC  = 4;
  localparam int OSC_FRC  = 0;
  localparam int OSC_PRI  = 1;
  localparam int OSC_SEC  = 2;
  localparam int OSC_SLOW_RC_OSCILLATOR = 3;
  typedef logic [NUM_OSC-1:0] clkss_osc_t;

  // ==========================================================
  // unlock keys and control word layout
  localparam logic [7:0] KEY_HI1 = 8'h78;
  localparam logic [7:0] KEY_HI2 = 8'h9a;
  localparam logic [7:0] KEY_LO1 = 8'h46;
  localparam logic [7:0] KEY_LO2 = 8'h57;

  localparam int BIT_REQ     = 0;
  localparam int BIT_KEEP    = 1;
  localparam int BIT_CF      = 3;
  localparam int BIT_LOCK    = 5;
  localparam int BIT_FREEZE  = 7;
  localparam int NEXT_LSB    = 8;
  localparam int CUR_LSB     = 12;
  localparam int HI_NEXT_LSB = 0;
  localparam int SRC_W       = 3;

  localparam int         MODE_SW_OFF  = 1;
  localparam logic [1:0] MODE_SW_ONLY = 2'h1;

  typedef enum logic [1:0] {UL_IDLE, UL_KEY1, UL_OPEN} clkss_unlock_e;

  // ==========================================================
  // helpers
  function automatic clkss_osc_t osc_of(input clkss_src_t s);
    clkss_osc_t o;
    o = '0;
    unique case (s)
      SRC_PRI, SRC_PRI_PLL: o[OSC_PRI] = 1'b1;
      SRC_SEC:              o[OSC_SEC] = 1'b1;
      SRC_SLOW_RC_OSCILLATOR:             o[OSC_SLOW_RC_OSCILLATOR] = 1'b1;
      default:              o[OSC_FRC] = 1'b1;
    endcase
    return o;
  endfunction

  function automatic logic uses_pll(input clkss_src_t s);
    return (s == SRC_FRC_PLL) || (s == SRC_PRI_PLL);
  endfunction

  function automatic logic is_crystal(input clkss_src_t s, input logic pri_xtal);
    return (s == SRC_SEC) || (pri_xtal && ((s == SRC_PRI) || (s == SRC_PRI_PLL)));
  endfunction

  // one write per cycle; the window opens for the single cycle after the second key
  function automatic clkss_unlock_e unlock_next(input clkss_unlock_e st, input logic wr,
                                                input logic [7:0] d, input logic [7:0] k1,
                                                input logic [7:0] k2);
    if (wr && d == k1) begin
      return UL_KEY1;
    end
    if (st == UL_KEY1 && wr && d == k2) begin
      return UL_OPEN;
    end
    return UL_IDLE;
  endfunction

endpackage

// *** common/clkss_mux_if.sv ***
// handover request channel between the switch sequencer and the clock mux
// assumes: both ends on the same clock
`timescale 1ns/1ps
`default_nettype none
interface clkss_mux_if;
  import clkss_pkg::*;
  logic       req;
  clkss_src_t target;
  logic       ack;
  modport ctrl (output req, output target, input ack);
  modport mux  (input req, input target, output ack);
endinterface
`default_nettype wire

// *** hdl/clkss_handover.sv ***
// glitch-free handover sequencer for the system clock multiplexer
// assumes: a one-cycle req with a stable target; next req only after ack
`timescale 1ns/1ps
`default_nettype none
module clkss_handover
  import clkss_pkg::*;
#(
  parameter int GUARD_CYC = 4
) (
  input  wire logic clk,
  input  wire logic rst,
  clkss_mux_if.mux  hand,
  output var  clkss_src_t sel_q,
  output var  logic       gate_q
);

  typedef enum logic [1:0] {H_IDLE, H_OFF, H_SEL, H_ON} clkss_hand_e;

  clkss_hand_e      st_q;
  clkss_src_t       tgt_q;
  logic [15:0]      cnt_q;
  logic             ack_q;

  assign hand.ack = ack_q;

  // ==========================================================
  // gate off, wait out the old clock, swap, wait on the new, gate on
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q   <= H_IDLE;
      tgt_q  <= SRC_FRC;
      cnt_q  <= '0;
      sel_q  <= SRC_FRC;
      gate_q <= 1'b1;
      ack_q  <= 1'b0;
    end else begin
      ack_q <= 1'b0;
      unique case (st_q)
        H_IDLE: begin
          if (hand.req) begin
            tgt_q  <= hand.target;
            gate_q <= 1'b0;
            cnt_q  <= '0;
            st_q   <= H_OFF;
          end
        end
        H_OFF: begin
          // never change select while the old clock may be mid-pulse
          cnt_q <= cnt_q + 16'h0001;
          if (cnt_q == 16'(GUARD_CYC - 1)) begin
            sel_q <= tgt_q;
            cnt_q <= '0;
            st_q  <= H_SEL;
          end
        end
        H_SEL: begin
          cnt_q <= cnt_q + 16'h0001;
          if (cnt_q == 16'(GUARD_CYC - 1)) begin
            gate_q <= 1'b1;
            st_q   <= H_ON;
          end
        end
        H_ON: begin
          ack_q <= 1'b1;
          st_q  <= H_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// *** hdl/clkss_ctrl.sv ***
// clock source switch controller: unlock, switch sequencing, fail-safe, source enables
// assumes: one write per cycle stands for one instruction; fuse inputs are static;
// oscillator ready, pll lock and clock fail come from other domains
`timescale 1ns/1ps
`default_nettype none
module clkss_ctrl
  import clkss_pkg::*;
#(
  parameter int OST_CYC   = 1024,
  parameter int GUARD_CYC = 4
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             wr_lo_en,
  input  wire logic             wr_hi_en,
  input  wire logic [7:0]       wr_data,
  input  wire logic             sleep_req,
  input  wire logic [1:0]       switch_mode_cfg,
  input  wire logic             pll_settle_wait_cfg,
  input  wire logic             two_speed_cfg,
  input  wire clkss_src_t       init_source_cfg,
  input  wire logic             pri_crystal_cfg,
  input  wire logic             watchdog_fuse_cfg,
  input  wire clkss_osc_t       osc_ready_in,
  input  wire logic             pll_lock_in,
  input  wire logic             clock_fail_in,
  output logic [15:0]           osc_control_q,
  output clkss_osc_t            osc_enable_q,
  output logic                  pll_enable_q,
  output clkss_src_t            clk_sel_q,
  output logic                  clk_gate_q,
  output logic                  cpu_hold_q,
  output logic                  switch_busy_q
);

  typedef enum logic [2:0] {S_IDLE, S_WAIT, S_OST, S_LOCK, S_HAND} clkss_state_e;

  clkss_state_e      st_q;
  clkss_unlock_e     ul_hi_q;
  clkss_unlock_e     ul_lo_q;
  clkss_src_t        cur_q;
  clkss_src_t        next_q;
  clkss_src_t        tgt_q;
  logic              req_q;
  logic              hw_q;
  logic              cf_q;
  logic              lock_q;
  logic              keep_q;
  logic              freeze_q;
  logic              boot_q;
  logic              mux_req_q;
  logic [15:0]       ost_q;
  clkss_osc_t        rdy_m_q;
  clkss_osc_t        rdy_s_q;
  logic [1:0]        lock_m_q;
  logic [1:0]        fail_m_q;
  logic              fail_d_q;

  logic              sw_en;
  logic              mon_en;
  logic              busy;
  logic              go;
  logic              ev_redundant;
  logic              ev_start;
  logic              ev_done;
  logic              ev_abort;
  logic              ev_sleep;
  logic              ev_fail;
  logic              tgt_ready;
  logic              hi_open;
  logic              lo_open;
  clkss_osc_t        cur_osc;
  clkss_osc_t        tgt_osc;

  clkss_mux_if hand ();

  // ==========================================================
  // synchronisers for the oscillator side indications
  // the fail edge comes from the synchronised copy, so a held fault acts only once
  always_ff @(posedge clk) begin
    if (rst) begin
      rdy_m_q  <= '0;
      rdy_s_q  <= '0;
      lock_m_q <= '0;
      fail_m_q <= '0;
      fail_d_q <= 1'b0;
    end else begin
      rdy_m_q  <= osc_ready_in;
      rdy_s_q  <= rdy_m_q;
      lock_m_q <= {lock_m_q[0], pll_lock_in};
      fail_m_q <= {fail_m_q[0], clock_fail_in};
      fail_d_q <= fail_m_q[1];
    end
  end

  // ==========================================================
  // mode decode and event conditions
  always_comb begin
    sw_en  = ~switch_mode_cfg[MODE_SW_OFF];
    mon_en = sw_en & ~switch_mode_cfg[0];
    busy   = (st_q != S_IDLE);
    // one-hot views of the current and target sources, shared by ready test and enables
    cur_osc = osc_of(cur_q);
    tgt_osc = osc_of(tgt_q);
    // a frozen word under mode 01 stops software switches only
    go = hw_q | (req_q & sw_en & ~(freeze_q & (switch_mode_cfg == MODE_SW_ONLY)));
    tgt_ready = |(tgt_osc & rdy_s_q);
    ev_fail = mon_en & fail_m_q[1] & ~fail_d_q & (cur_q != SRC_FRC) & (st_q != S_HAND);
    ev_redundant = ~boot_q & ~busy & go & (next_q == cur_q) & ~ev_fail;
    ev_start     = ~boot_q & ~busy & go & (next_q != cur_q) & ~ev_fail;
    ev_done      = (st_q == S_HAND) & hand.ack;
    // hand-over already under way is allowed to finish
    ev_sleep = busy & (st_q != S_HAND) & sleep_req & ~ev_fail;
    ev_abort = busy & (st_q != S_HAND) & ~req_q & ~hw_q & ~ev_fail;
  end

  // ==========================================================
  // switch sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q      <= S_IDLE;
      tgt_q     <= SRC_FRC;
      ost_q     <= '0;
      mux_req_q <= 1'b0;
    end else begin
      mux_req_q <= 1'b0;
      if (ev_fail) begin
        // old clock is dead, so go straight to the mux with fast rc
        tgt_q     <= SRC_FRC;
        ost_q     <= '0;
        mux_req_q <= 1'b1;
        st_q      <= S_HAND;
      end else if (ev_abort || ev_sleep) begin
        ost_q <= '0;
        st_q  <= S_IDLE;
      end else begin
        unique case (st_q)
          S_IDLE: begin
            if (ev_start) begin
              // the startup timer restarts from zero for every new target
              tgt_q <= next_q;
              ost_q <= '0;
              st_q  <= S_WAIT;
            end
          end
          S_WAIT: begin
            // old clock keeps running; an absent source waits here until an abort, sleep or fail
            if (tgt_ready) begin
              if (is_crystal(tgt_q, pri_crystal_cfg)) begin
                st_q <= S_OST;
              end else if (uses_pll(tgt_q) && pll_settle_wait_cfg) begin
                st_q <= S_LOCK;
              end else begin
                mux_req_q <= 1'b1;
                st_q      <= S_HAND;
              end
            end
          end
          S_OST: begin
            ost_q <= ost_q + 16'h0001;
            if (ost_q == 16'(OST_CYC - 1)) begin
              if (uses_pll(tgt_q) && pll_settle_wait_cfg) begin
                st_q <= S_LOCK;
              end else begin
                mux_req_q <= 1'b1;
                st_q      <= S_HAND;
              end
            end
          end
          S_LOCK: begin
            if (lock_m_q[1]) begin
              mux_req_q <= 1'b1;
              st_q      <= S_HAND;
            end
          end
          S_HAND: begin
            if (hand.ack) begin
              st_q <= S_IDLE;
            end
          end
        endcase
      end
    end
  end

  assign hand.req    = mux_req_q;
  assign hand.target = tgt_q;

  clkss_handover #(
    .GUARD_CYC (GUARD_CYC)
  ) u_hand (
    .clk    (clk),
    .rst    (rst),
    .hand   (hand.mux),
    .sel_q  (clk_sel_q),
    .gate_q (clk_gate_q)
  );

  // ==========================================================
  // unlock tracking; any other or late write drops back to idle
  // a data byte equal to the first key is taken and also starts a new pattern
  always_ff @(posedge clk) begin
    if (rst) begin
      ul_hi_q <= UL_IDLE;
      ul_lo_q <= UL_IDLE;
    end else begin
      ul_hi_q <= unlock_next(ul_hi_q, wr_hi_en, wr_data, KEY_HI1, KEY_HI2);
      ul_lo_q <= unlock_next(ul_lo_q, wr_lo_en, wr_data, KEY_LO1, KEY_LO2);
    end
  end

  // open for the single cycle after the second key
  assign hi_open = (ul_hi_q == UL_OPEN) & wr_hi_en & ~wr_lo_en;
  assign lo_open = (ul_lo_q == UL_OPEN) & wr_lo_en & ~wr_hi_en;

  // ==========================================================
  // control and status word
  always_ff @(posedge clk) begin
    if (rst) begin
      boot_q     <= 1'b1;
      cur_q      <= SRC_FRC;
      next_q     <= SRC_FRC;
      req_q      <= 1'b0;
      hw_q       <= 1'b0;
      cf_q       <= 1'b0;
      lock_q     <= 1'b0;
      keep_q     <= 1'b0;
      freeze_q   <= 1'b0;
      cpu_hold_q <= 1'b0;
    end else begin
      // boot_q stands for one cycle only, so the fuse source is caught exactly once
      boot_q <= 1'b0;
      lock_q <= lock_m_q[1];
      if (boot_q) begin
        // the start source is caught after release and reached by a hardware switch
        next_q     <= init_source_cfg;
        hw_q       <= (init_source_cfg != SRC_FRC);
        cpu_hold_q <= ~two_speed_cfg & (init_source_cfg != SRC_FRC);
      end
      if (ev_redundant) begin
        req_q <= 1'b0;
        hw_q  <= 1'b0;
      end
      if (ev_start) begin
        cf_q   <= 1'b0;
        lock_q <= 1'b0;
      end
      if (ev_done) begin
        cur_q      <= tgt_q;
        req_q      <= 1'b0;
        hw_q       <= 1'b0;
        cpu_hold_q <= 1'b0;
      end
      if (ev_sleep) begin
        req_q <= 1'b0;
        hw_q  <= 1'b0;
      end
      if (ev_fail) begin
        cur_q      <= SRC_FRC;
        cf_q       <= 1'b1;
        req_q      <= 1'b0;
        hw_q       <= 1'b0;
        cpu_hold_q <= 1'b0;
      end
      // software writes last; while busy only the abort clear gets through
      if (hi_open && !busy) begin
        next_q <= wr_data[HI_NEXT_LSB +: SRC_W];
      end
      if (lo_open && !busy && !ev_fail) begin
        req_q  <= wr_data[BIT_REQ];
        keep_q <= wr_data[BIT_KEEP];
        if (wr_data[BIT_FREEZE]) begin
          freeze_q <= 1'b1;
        end
      end else if (lo_open && busy && !wr_data[BIT_REQ]) begin
        req_q <= 1'b0;
        hw_q  <= 1'b0;
      end
    end
  end

  // ==========================================================
  // oscillator and pll enables; the target joins the old source until done
  always_ff @(posedge clk) begin
    if (rst) begin
      osc_enable_q  <= clkss_osc_t'(1 << OSC_FRC);
      pll_enable_q  <= 1'b0;
      switch_busy_q <= 1'b0;
      osc_control_q <= '0;
    end else begin
      osc_enable_q <= cur_osc | (busy ? tgt_osc : '0);
      osc_enable_q[OSC_SLOW_RC_OSCILLATOR] <= cur_osc[OSC_SLOW_RC_OSCILLATOR] | (busy & tgt_osc[OSC_SLOW_RC_OSCILLATOR])
                                | watchdog_fuse_cfg | mon_en;
      osc_enable_q[OSC_SEC] <= cur_osc[OSC_SEC] | (busy & tgt_osc[OSC_SEC])
                               | keep_q;
      // fast rc stays on under the monitor so a fail-safe handover finds it running
      osc_enable_q[OSC_FRC] <= cur_osc[OSC_FRC] | (busy & tgt_osc[OSC_FRC])
                               | mon_en | boot_q;
      // an aborted pll target drops out here with the target term
      pll_enable_q  <= uses_pll(cur_q) | (busy & uses_pll(tgt_q));
      switch_busy_q <= busy;
      osc_control_q <= '0;
      osc_control_q[CUR_LSB +: SRC_W]  <= cur_q;
      osc_control_q[NEXT_LSB +: SRC_W] <= next_q;
      osc_control_q[BIT_FREEZE]        <= freeze_q;
      osc_control_q[BIT_LOCK]          <= lock_q;
      osc_control_q[BIT_CF]            <= cf_q;
      osc_control_q[BIT_KEEP]          <= keep_q;
      osc_control_q[BIT_REQ]           <= req_q;
    end
  end

endmodule
`default_nettype wire

// *** test/clkss_ctrl_checker.sv ***
// assertions on the ports of the clock source switch controller
// assumes: bound into clkss_ctrl; one clock, sync active-high reset
`timescale 1ns/1ps
`default_nettype none
module clkss_ctrl_checker
  import clkss_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        wr_hi_en,
  input wire logic [1:0]  switch_mode_cfg,
  input wire logic        pll_settle_wait_cfg,
  input wire logic        pll_lock_in,
  input wire logic        clock_fail_in,
  input wire logic [15:0] osc_control_q,
  input wire clkss_osc_t  osc_enable_q,
  input wire clkss_src_t  clk_sel_q,
  input wire logic        clk_gate_q,
  input wire logic        switch_busy_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ==========================================================
  // helpers
  clkss_src_t cur;
  clkss_src_t nxt;
  clkss_osc_t sel_osc;
  assign cur = osc_control_q[14:12];
  assign nxt = osc_control_q[10:8];
  // own mapping, so a slip in the package helper cannot hide here
  assign sel_osc = (clk_sel_q inside {3'h2, 3'h3}) ? 4'h2 : (clk_sel_q == 3'h4) ? 4'h4 :
                   (clk_sel_q == 3'h5) ? 4'h8 : 4'h1;

  // ==========================================================
  // assertions
  a_freeze_sticky: assert property (osc_control_q[7] |=> osc_control_q[7])
    else $error("freeze bit cleared without reset");
  a_busy_hi_write: assert property ((switch_busy_q && wr_hi_en) ##1 switch_busy_q
    |=> $stable(nxt)) else $error("high byte taken during a switch");
  a_current_source: assert property ($changed(cur) |-> cur == nxt || cur == 3'h0)
    else $error("current source not from next or fail-safe");
  a_sel_gated: assert property ($changed(clk_sel_q) |-> !clk_gate_q && !$past(clk_gate_q))
    else $error("mux select moved while clock passed");
  a_new_running: assert property ($changed(clk_sel_q) |-> |(osc_enable_q & sel_osc))
    else $error("mux moved to a disabled oscillator");
  a_lock_first: assert property ($changed(clk_sel_q) && clk_sel_q inside {3'h1, 3'h3}
    && pll_settle_wait_cfg |-> $past(pll_lock_in, 4)) else $error("pll source taken unlocked");
  a_equal_drop: assert property (osc_control_q[0] && nxt == cur && !switch_busy_q
    && !switch_mode_cfg[1] && !osc_control_q[7] |-> ##[1:4] !osc_control_q[0])
    else $error("redundant request not dropped");
  a_fail_safe: assert property ($rose(clock_fail_in) && switch_mode_cfg == 2'h0
    && cur != 3'h0 && !switch_busy_q |-> ##[1:6] (cur == 3'h0 && osc_control_q[3]))
    else $error("fail-safe did not move to fast rc");

  c_handover: cover property ($fell(clk_gate_q));
  c_fail: cover property ($rose(osc_control_q[3]));
  c_busy_write: cover property (switch_busy_q && wr_hi_en);
endmodule
bind clkss_ctrl clkss_ctrl_checker clkss_ctrl_checker_i (
  .clk                 (clk),
  .rst                 (rst),
  .wr_hi_en            (wr_hi_en),
  .switch_mode_cfg     (switch_mode_cfg),
  .pll_settle_wait_cfg (pll_settle_wait_cfg),
  .pll_lock_in         (pll_lock_in),
  .clock_fail_in       (clock_fail_in),
  .osc_control_q       (osc_control_q),
  .osc_enable_q        (osc_enable_q),
  .clk_sel_q           (clk_sel_q),
  .clk_gate_q          (clk_gate_q),
  .switch_busy_q       (switch_busy_q)
);
`default_nettype wire

// *** test/clkss_osc_model.sv ***
// oscillators and pll: each reports ready a few cycles after its enable
// assumes: absent sources and lost lock are commanded by the bench
`timescale 1ns/1ps
`default_nettype none
module clkss_osc_model
  import clkss_pkg::*;
#(
  parameter int DLY = 3
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire clkss_osc_t osc_en,
  input  wire logic       pll_en,
  input  wire clkss_osc_t absent,
  input  wire logic       lose_lock,
  output var  clkss_osc_t osc_rdy,
  output var  logic       lock
);
  logic [4:0] on;
  logic [2:0] cnt [5];
  // a disabled or absent source drops ready at once, never holds it
  assign on = {pll_en & ~lose_lock, osc_en & ~absent};

  always_ff @(posedge clk) begin
    for (int i = 0; i < 5; i++) begin
      if (rst) begin
        cnt[i] <= 3'h0;
      end else begin
        cnt[i] <= !on[i] ? 3'h0 : cnt[i] + 3'(cnt[i] != 3'(DLY));
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      osc_rdy[i] = on[i] && cnt[i] == 3'(DLY);
    end
    lock = on[4] && cnt[4] == 3'(DLY);
  end
endmodule
`default_nettype wire

// *** test/clkss_ctrl_tb_top.sv ***
// self-checking bench for the clock source switch controller
// assumes: oscillator model on the far side; fuses change only under reset
`timescale 1ns/1ps
`default_nettype none
module clkss_ctrl_tb_top
  import clkss_pkg::*;
;
  logic        clk, rst, wr_lo, wr_hi, sleep, pllw, ts, fail, lose, pll_en, hold, busy;
  logic [1:0]  mode;
  logic [7:0]  wd;
  logic [15:0] oc;
  clkss_src_t  init;
  clkss_osc_t  en, rdy, absent;
  logic        lock;
  logic        gate;
  clkss_src_t  sel;
  int          mismatches, tests_run;

  clkss_ctrl #(.OST_CYC(8), .GUARD_CYC(2)) clkss_ctrl_i (
    .clk(clk), .rst(rst), .wr_lo_en(wr_lo), .wr_hi_en(wr_hi), .wr_data(wd),
    .sleep_req(sleep), .switch_mode_cfg(mode), .pll_settle_wait_cfg(pllw),
    .two_speed_cfg(ts), .init_source_cfg(init), .pri_crystal_cfg(1'b1),
    .watchdog_fuse_cfg(1'b0), .osc_ready_in(rdy), .pll_lock_in(lock),
    .clock_fail_in(fail), .osc_control_q(oc), .osc_enable_q(en), .pll_enable_q(pll_en),
    .clk_sel_q(sel), .clk_gate_q(gate), .cpu_hold_q(hold), .switch_busy_q(busy));
  clkss_osc_model clkss_osc_model_i (.clk(clk), .rst(rst), .osc_en(en), .pll_en(pll_en),
    .absent(absent), .lose_lock(lose), .osc_rdy(rdy), .lock(lock));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ==========================================================
  // tasks
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // n back-to-back byte writes, one per cycle, taken from the top of s
  task automatic wr(input logic hi, input logic [31:0] s, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      wr_hi <= hi;
      wr_lo <= !hi;
      wd <= s[31-8*i -: 8];
    end
    @(posedge clk);
    wr_hi <= 1'b0;
    wr_lo <= 1'b0;
  endtask

  task automatic sw(input clkss_src_t s);
    wr(1'b1, {KEY_HI1, KEY_HI2, 5'h0, s, 8'h0}, 3);
    wr(1'b0, {KEY_LO1, KEY_LO2, 16'h0100}, 3);
  endtask

  task automatic done(input clkss_src_t s);
    idle(3);
    // a hardware switch never sets the request bit, so wait on busy as well
    for (int i = 0; i < 400 && (oc[0] !== 1'b0 || busy !== 1'b0); i++) idle(1);
    chk("busy", busy, 1'b0);
    chk("req", oc[0], 1'b0);
    chk("cur", oc[14:12], s);
    chk("sel", sel, s);
    chk("gate", gate, 1'b1);
  endtask

  task automatic boot(input logic [1:0] m, input logic p, input clkss_src_t s, input logic t);
    @(posedge clk);
    rst <= 1'b1;
    mode <= m;
    pllw <= p;
    init <= s;
    ts <= t;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    idle(2);
  endtask

  task automatic final_report;
    if (mismatches == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // tests
  initial begin
    rst = 1'b1;
    {wr_lo, wr_hi, sleep, fail, lose, mode, wd, absent} = '0;
    {pllw, ts, init} = '0;
    for (int t = 0; t < 2; t++) begin
      boot(2'h0, 1'b1, SRC_PRI, t[0]);
      chk("hold", hold, !t[0]);
      done(SRC_PRI);
      chk("hold", hold, 1'b0);
    end
    sw(SRC_PRI);
    done(SRC_PRI);
    sw(SRC_FRC_PLL);
    done(SRC_FRC_PLL);
    chk("lock", oc[5], 1'b1);
    chk("pri en", en[OSC_PRI], 1'b0);
    // always back to a plain source between pll sources
    sw(SRC_FRC);
    done(SRC_FRC);
    @(posedge clk) lose <= 1'b1;
    sw(SRC_PRI_PLL);
    idle(40);
    chk("req", oc[0], 1'b1);
    chk("lock", oc[5], 1'b0);
    chk("cur", oc[14:12], SRC_FRC);
    wr(1'b1, {KEY_HI1, KEY_HI2, 8'h05, 8'h0}, 3);
    idle(2);
    chk("nxt", oc[10:8], SRC_PRI_PLL);
    wr(1'b0, {KEY_LO1, KEY_LO2, 16'h0}, 3);
    done(SRC_FRC);
    chk("busy", busy, 1'b0);
    chk("pll", pll_en, 1'b0);
    @(posedge clk) lose <= 1'b0;
    absent <= 4'h4;
    sw(SRC_SEC);
    idle(10);
    @(posedge clk) sleep <= 1'b1;
    idle(3);
    @(posedge clk) sleep <= 1'b0;
    done(SRC_FRC);
    @(posedge clk) absent <= 4'h0;
    wr(1'b1, {KEY_HI1, 8'h00, 8'h05, 8'h0}, 3);
    wr(1'b1, {KEY_HI1, KEY_HI2, 16'h0}, 2);
    wr(1'b1, {8'h05, 24'h0}, 1);
    idle(2);
    chk("nxt", oc[10:8], SRC_SEC);
    wr(1'b1, {KEY_HI1, KEY_HI2, 8'h06, 8'h07}, 4);
    idle(2);
    chk("nxt", oc[10:8], SRC_FRC16);
    sw(SRC_SLOW_RC_OSCILLATOR);
    done(SRC_SLOW_RC_OSCILLATOR);
    @(posedge clk) fail <= 1'b1;
    idle(8);
    chk("cur", oc[14:12], SRC_FRC);
    chk("cf", oc[3], 1'b1);
    @(posedge clk) fail <= 1'b0;
    sw(SRC_SEC);
    done(SRC_SEC);
    chk("cf", oc[3], 1'b0);
    chk("slow_rc_oscillator en", en[OSC_SLOW_RC_OSCILLATOR], 1'b1);
    boot(2'h1, 1'b0, SRC_FRC, 1'b1);
    @(posedge clk) lose <= 1'b1;
    sw(SRC_PRI_PLL);
    done(SRC_PRI_PLL);
    @(posedge clk) lose <= 1'b0;
    wr(1'b0, {KEY_LO1, KEY_LO2, 16'h8200}, 3);
    wr(1'b0, {KEY_LO1, KEY_LO2, 16'h0200}, 3);
    idle(2);
    chk("keep", oc[1], 1'b1);
    chk("sec en", en[OSC_SEC], 1'b1);
    sw(SRC_FRC);
    idle(40);
    chk("freeze", oc[7], 1'b1);
    chk("cur", oc[14:12], SRC_PRI_PLL);
    boot(2'h2, 1'b1, SRC_SLOW_RC_OSCILLATOR, 1'b1);
    done(SRC_SLOW_RC_OSCILLATOR);
    @(posedge clk) fail <= 1'b1;
    sw(SRC_FRC);
    idle(40);
    chk("cur", oc[14:12], SRC_SLOW_RC_OSCILLATOR);
    chk("cf", oc[3], 1'b0);
    final_report;
  end

  // generous bound: the sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    final_report;
  end
endmodule
`default_nettype wire
